// ==== core/sbapp_pkg.sv ====
// Purpose: Shared constants and types for the shared bus arbiter and panel port
// Assumes: One system clock, asynchronous active-low reset
// Notes:   Bank codes sit in the top address bits; panel offsets in the low bits
package sbapp_pkg;

  localparam int          SBAPP_ADDR_W     = 20;
  localparam int          SBAPP_DATA_W     = 16;
  localparam int          SBAPP_BANK_W     = 2;
  localparam int          SBAPP_KEY_W      = 8;
  localparam int          SBAPP_KNOB_W     = 8;
  localparam int          SBAPP_LAMP_W     = 8;
  localparam int          SBAPP_REQ_MAX    = 8;

  // ----------------------------------------------------------------
  // Bank decode (top address bits)
  // ----------------------------------------------------------------
  localparam logic [1:0]  SBAPP_BANK_RAM   = 2'h0;
  localparam logic [1:0]  SBAPP_BANK_CARD  = 2'h1;
  localparam logic [1:0]  SBAPP_BANK_PANEL = 2'h2;

  // ----------------------------------------------------------------
  // Panel offsets (low address bits)
  // ----------------------------------------------------------------
  localparam logic [1:0]  SBAPP_PNL_KEY    = 2'h0;
  localparam logic [1:0]  SBAPP_PNL_KNOB   = 2'h1;
  localparam logic [1:0]  SBAPP_PNL_LAMP   = 2'h2;

  localparam logic [7:0]  SBAPP_LAMP_RST   = 8'h00;
  localparam logic [7:0]  SBAPP_KNOB_RST   = 8'h00;

  typedef struct packed {
    logic                    valid;
    logic                    wr;
    logic [SBAPP_ADDR_W-1:0] addr;
    logic [SBAPP_DATA_W-1:0] wdata;
  } sbapp_req_t;

  typedef enum logic [1:0] {
    SBAPP_SEL_RAM   = 2'b00,
    SBAPP_SEL_CARD  = 2'b01,
    SBAPP_SEL_PANEL = 2'b10,
    SBAPP_SEL_NONE  = 2'b11
  } sbapp_sel_t;

endpackage : sbapp_pkg

// ==== core/sbapp_top.sv ====
// Purpose: Shared bus arbiter, bank decoder and front-panel port
// Assumes: Requesters hold request while owning; owner's access on i_acc
// Notes:   Lowest requester index has highest priority
`timescale 1ns/100ps
module sbapp_top
  import sbapp_pkg::*;
#(
  parameter int N_REQ = 4
)(
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_b,
  input  wire logic [N_REQ-1:0]        i_req,
  output logic      [N_REQ-1:0]        o_gnt,
  input  wire sbapp_req_t              i_acc,
  output logic      [SBAPP_DATA_W-1:0] o_rdata,
  output logic                         o_rvalid,
  output logic                         o_ram_sel,
  output logic                         o_card_sel,
  output logic                         o_wr,
  output logic      [SBAPP_ADDR_W-1:0] o_addr,
  output logic      [SBAPP_DATA_W-1:0] o_wdata,
  input  wire logic [SBAPP_DATA_W-1:0] i_ram_rdata,
  input  wire logic [SBAPP_DATA_W-1:0] i_card_rdata,
  input  wire logic                    i_key_stb,
  input  wire logic [SBAPP_KEY_W-1:0]  i_key_code,
  input  wire logic                    i_knob_a,
  input  wire logic                    i_knob_b,
  output logic                         o_key_irq,
  output logic      [SBAPP_LAMP_W-1:0] o_lamp
);

  // Grant vector and priority loop cannot serve an empty or oversized requester set
  if (N_REQ < 1 || N_REQ > SBAPP_REQ_MAX)
  begin : g_bad_n_req
    $error("N_REQ out of range");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic sbapp_sel_t bank_of(input logic [SBAPP_ADDR_W-1:0] a);
    logic [SBAPP_BANK_W-1:0] b;
    b = a[SBAPP_ADDR_W-1 -: SBAPP_BANK_W];
    if (b == SBAPP_BANK_RAM)
      return SBAPP_SEL_RAM;
    else if (b == SBAPP_BANK_CARD)
      return SBAPP_SEL_CARD;
    else if (b == SBAPP_BANK_PANEL)
      return SBAPP_SEL_PANEL;
    return SBAPP_SEL_NONE;
  endfunction : bank_of

  // ----------------------------------------------------------------
  // Input synchronisers for pins
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [SBAPP_KEY_W-1:0] key_s1_r;
  logic [SBAPP_KEY_W-1:0] key_s2_r;
  logic [1:0] ab_prev_r;
  logic       stb_prev_r;

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_s1_r   <= 3'h0;
      pin_s2_r   <= 3'h0;
      key_s1_r   <= 8'h00;
      key_s2_r   <= 8'h00;
      ab_prev_r  <= 2'h0;
      stb_prev_r <= 1'b0;
    end
    else
    begin
      pin_s1_r   <= {i_key_stb, i_knob_b, i_knob_a};
      pin_s2_r   <= pin_s1_r;
      key_s1_r   <= i_key_code;
      key_s2_r   <= key_s1_r;
      ab_prev_r  <= pin_s2_r[1:0];
      stb_prev_r <= pin_s2_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  logic [N_REQ-1:0] gnt_r;
  logic [N_REQ-1:0] gnt_nxt;

  always_comb
  begin
    gnt_nxt = gnt_r;
    if ((gnt_r & i_req) == '0)
    begin
      gnt_nxt = '0;
      for (int i = N_REQ - 1; i >= 0; i--)
        if (i_req[i])
          gnt_nxt = N_REQ'(1) << i;
    end
    // Owner still requesting: others wait
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      gnt_r <= '0;
    else
      gnt_r <= gnt_nxt;
  end

  assign o_gnt = gnt_r;

  // ----------------------------------------------------------------
  // Bank decode and panel registers
  // ----------------------------------------------------------------
  logic                    own;
  sbapp_sel_t              sel;
  logic                    ram_sel_nxt, card_sel_nxt, rvalid_nxt, wr_nxt;
  logic                    ram_sel_r, card_sel_r, rvalid_r, wr_r;
  logic [SBAPP_ADDR_W-1:0] addr_r;
  logic [SBAPP_DATA_W-1:0] wdata_r, rdata_r, rdata_nxt;
  logic [SBAPP_LAMP_W-1:0] lamp_r, lamp_nxt;
  logic [SBAPP_KEY_W-1:0]  key_r, key_nxt;
  logic                    irq_r, irq_nxt;
  logic signed [SBAPP_KNOB_W-1:0] knob_r, knob_nxt;
  logic                    key_rd, knob_rd, key_evt, step_up, step_dn;
  logic [1:0]              ab;

  assign own     = i_acc.valid && (gnt_r != '0);
  assign sel     = bank_of(i_acc.addr);
  assign ab      = pin_s2_r[1:0];
  assign key_evt = pin_s2_r[2] && !stb_prev_r;
  assign key_rd  = own && !i_acc.wr && sel == SBAPP_SEL_PANEL
                   && i_acc.addr[1:0] == SBAPP_PNL_KEY;
  assign knob_rd = own && !i_acc.wr && sel == SBAPP_SEL_PANEL
                   && i_acc.addr[1:0] == SBAPP_PNL_KNOB;
  // Gray sequence 00-01-11-10 counts up; A leads B
  // A double step has no direction, so it is dropped rather than guessed
  assign step_up = (ab_prev_r ^ ab) != 2'h0 && (ab_prev_r ^ ab) != 2'h3
                   && !(ab_prev_r[0] ^ ab[1]);
  assign step_dn = (ab_prev_r ^ ab) != 2'h0 && (ab_prev_r ^ ab) != 2'h3
                   && (ab_prev_r[0] ^ ab[1]);

  always_comb
  begin
    ram_sel_nxt  = own && sel == SBAPP_SEL_RAM;
    card_sel_nxt = own && sel == SBAPP_SEL_CARD;
    wr_nxt       = own && i_acc.wr;
    rvalid_nxt   = own && !i_acc.wr;
    rdata_nxt    = '0;
    lamp_nxt     = lamp_r;
    key_nxt      = key_r;
    irq_nxt      = irq_r;
    knob_nxt     = knob_r;
    unique case (sel)
      SBAPP_SEL_RAM:   rdata_nxt = i_ram_rdata;
      SBAPP_SEL_CARD:  rdata_nxt = i_card_rdata;
      SBAPP_SEL_PANEL:
        unique case (i_acc.addr[1:0])
          SBAPP_PNL_KEY:  rdata_nxt = {8'h00, key_r};
          SBAPP_PNL_KNOB: rdata_nxt = {{8{knob_r[7]}}, knob_r};
          SBAPP_PNL_LAMP: rdata_nxt = {8'h00, lamp_r};
          default:        rdata_nxt = '0;
        endcase
      SBAPP_SEL_NONE:  rdata_nxt = '0;
    endcase
    if (own && i_acc.wr && sel == SBAPP_SEL_PANEL && i_acc.addr[1:0] == SBAPP_PNL_LAMP)
      lamp_nxt = i_acc.wdata[SBAPP_LAMP_W-1:0];
    if (key_rd)
      irq_nxt = 1'b0;
    // New key wins over a clearing read in the same cycle
    if (key_evt)
    begin
      key_nxt = key_s2_r;
      irq_nxt = 1'b1;
    end
    // Read clears, but a step in the same cycle is kept; pins are sampled every clock
    if (knob_rd)
      knob_nxt = SBAPP_KNOB_RST;
    if (step_up)
      knob_nxt = knob_nxt + 8'sh01;
    else if (step_dn)
      knob_nxt = knob_nxt - 8'sh01;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ram_sel_r  <= 1'b0;
      card_sel_r <= 1'b0;
      wr_r       <= 1'b0;
      rvalid_r   <= 1'b0;
      addr_r     <= '0;
      wdata_r    <= '0;
      rdata_r    <= '0;
      lamp_r     <= SBAPP_LAMP_RST;
      key_r      <= 8'h00;
      irq_r      <= 1'b0;
      knob_r     <= SBAPP_KNOB_RST;
    end
    else
    begin
      ram_sel_r  <= ram_sel_nxt;
      card_sel_r <= card_sel_nxt;
      wr_r       <= wr_nxt;
      rvalid_r   <= rvalid_nxt;
      addr_r     <= i_acc.addr;
      wdata_r    <= i_acc.wdata;
      rdata_r    <= rdata_nxt;
      lamp_r     <= lamp_nxt;
      key_r      <= key_nxt;
      irq_r      <= irq_nxt;
      knob_r     <= knob_nxt;
    end
  end

  assign o_ram_sel  = ram_sel_r;
  assign o_card_sel = card_sel_r;
  assign o_wr       = wr_r;
  assign o_rvalid   = rvalid_r;
  assign o_addr     = addr_r;
  assign o_wdata    = wdata_r;
  assign o_rdata    = rdata_r;
  assign o_lamp     = lamp_r;
  assign o_key_irq  = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ONEHOT_GNT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $onehot0(gnt_r)) else $error("more than one grant");
  AST_PRIO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    ((gnt_r & i_req) == '0 && i_req[0]) |=> gnt_r[0]) else $error("priority broken");
  AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (gnt_r != '0 && (gnt_r & i_req) != '0) |=> $stable(gnt_r)) else $error("owner lost bus");
  AST_RELEASE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (gnt_r != '0 && (gnt_r & i_req) == '0 && i_req == '0) |=> gnt_r == '0)
    else $error("grant kept after release");
  AST_CARD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (own && sel == SBAPP_SEL_CARD) |=> o_card_sel && !o_ram_sel) else $error("card not selected");
  AST_RAM: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (own && sel == SBAPP_SEL_RAM) |=> o_ram_sel && !o_card_sel) else $error("ram not selected");
  AST_KEY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    key_evt |=> o_key_irq && key_r == $past(key_s2_r)) else $error("key not latched");
  AST_KEYCLR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (key_rd && !key_evt) |=> !o_key_irq) else $error("irq not cleared by read");
  AST_LAMP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (own && i_acc.wr && sel == SBAPP_SEL_PANEL && i_acc.addr[1:0] == SBAPP_PNL_LAMP)
    |=> o_lamp == $past(i_acc.wdata[7:0])) else $error("lamp not written");
  AST_KNOB: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (!knob_rd && step_up) |=> knob_r == $past(knob_r) + 8'sh01) else $error("knob miscount");
  AST_KNOB_DN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (!knob_rd && step_dn) |=> knob_r == $past(knob_r) - 8'sh01)
    else $error("knob miscount down");
  AST_KNOB_CLR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (knob_rd && !step_up && !step_dn) |=> knob_r == 8'sh00)
    else $error("knob not cleared by read");

endmodule : sbapp_top

// ==== bench/sbapp_tgt_model.sv ====
// Purpose: Read-data model of the shared RAM and the card behind the bus
// Assumes: Targets answer in the same cycle from the access address
// Notes:   Data is a pattern of the address, so no storage is needed
`timescale 1ns/100ps
module sbapp_tgt_model
  import sbapp_pkg::*;
(
  input  wire logic [SBAPP_ADDR_W-1:0] i_addr,
  output logic      [SBAPP_DATA_W-1:0] o_ram_rdata,
  output logic      [SBAPP_DATA_W-1:0] o_card_rdata
);
  // Different patterns so a bank mix-up cannot read back correctly
  assign o_ram_rdata  = i_addr[15:0] ^ 16'h5a5a;
  assign o_card_rdata = i_addr[15:0] ^ 16'hc3c3;
endmodule : sbapp_tgt_model

// ==== bench/sbapp_top_tb.sv ====
// Purpose: Self-checking bench for the arbiter, bank decode and panel port
// Assumes: Inputs change at the falling edge; outputs sampled there too
// Notes:   Knob and key inputs get slack for their synchronisers
`timescale 1ns/100ps
module sbapp_top_tb;
  import sbapp_pkg::*;
  logic                    i_ref_clk = 1'b0;
  logic                    i_rst_b   = 1'b0;
  logic [3:0]              i_req     = 4'h0;
  logic [3:0]              o_gnt;
  sbapp_req_t              i_acc     = '0;
  logic [SBAPP_DATA_W-1:0] o_rdata, o_wdata, ram_d, card_d;
  logic [SBAPP_ADDR_W-1:0] o_addr;
  logic [SBAPP_LAMP_W-1:0] o_lamp;
  logic [SBAPP_KEY_W-1:0]  i_key_code = 8'h00;
  logic o_rvalid, o_ram_sel, o_card_sel, o_wr, o_key_irq;
  logic i_key_stb = 1'b0, i_knob_a = 1'b0, i_knob_b = 1'b0;
  int   err_total = 0, checks_done = 0, cyc = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  sbapp_top #(.N_REQ(4)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .o_gnt(o_gnt), .i_acc(i_acc), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_ram_sel(o_ram_sel), .o_card_sel(o_card_sel), .o_wr(o_wr), .o_addr(o_addr),
    .o_wdata(o_wdata), .i_ram_rdata(ram_d), .i_card_rdata(card_d), .i_key_stb(i_key_stb),
    .i_key_code(i_key_code), .i_knob_a(i_knob_a), .i_knob_b(i_knob_b),
    .o_key_irq(o_key_irq), .o_lamp(o_lamp));
  sbapp_tgt_model tgt_u (.i_addr(i_acc.addr), .o_ram_rdata(ram_d), .o_card_rdata(card_d));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One access after an idle edge, so valid never drops and rises in one step
  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d,
                     input logic [15:0] exp, input logic [2:0] sel);
    @(negedge i_ref_clk);
    i_acc = '{valid: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge i_ref_clk);
    i_acc.valid = 1'b0;
    chk({13'h0, o_ram_sel, o_card_sel, o_rvalid}, {13'h0, sel});
    chk({12'h0, o_addr[19:16]}, {12'h0, a[19:16]});
    if (w)
      chk({o_wr, o_addr[14:0]}, {1'b1, a[14:0]});
    else if (sel[0])
      chk(o_rdata, exp);
  endtask : acc

  task automatic knob(input logic b, input logic a);
    {i_knob_b, i_knob_a} = {b, a};
    repeat (6) @(negedge i_ref_clk);
  endtask : knob

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_arb();
    i_req = 4'b1110;
    @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0002);
    i_req = 4'b1111;
    repeat (3) @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0002);
    i_req = 4'b1101;
    @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0001);
    i_req = 4'b1100;
    @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0004);
    i_req = 4'h0;
    @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0000);
  endtask : t_arb

  task automatic t_banks();
    acc(1'b0, 20'h01234, 16'h0, 16'h0, 3'b000);
    i_req = 4'b1000;
    @(negedge i_ref_clk);
    acc(1'b0, 20'h01234, 16'h0, 16'h1234 ^ 16'h5a5a, 3'b101);
    acc(1'b1, 20'h00042, 16'hbeef, 16'h0, 3'b100);
    chk(o_wdata, 16'hbeef);
    acc(1'b0, 20'h4abcd, 16'h0, 16'habcd ^ 16'hc3c3, 3'b011);
    acc(1'b1, 20'h40007, 16'h1357, 16'h0, 3'b010);
    acc(1'b0, 20'hc0010, 16'h0, 16'h0000, 3'b001);
    acc(1'b1, 20'h80002, 16'h00a5, 16'h0, 3'b000);
    chk({8'h0, o_lamp}, 16'h00a5);
    acc(1'b0, 20'h80002, 16'h0, 16'h00a5, 3'b001);
    acc(1'b0, 20'h80003, 16'h0, 16'h0000, 3'b001);
  endtask : t_banks

  task automatic t_key();
    int n;
    i_key_code = 8'h3c;
    i_key_stb  = 1'b1;
    for (n = 0; n < 8 && o_key_irq !== 1'b1; n++)
      @(negedge i_ref_clk);
    chk({15'h0, o_key_irq}, 16'h0001);
    i_key_stb = 1'b0;
    acc(1'b0, 20'h80000, 16'h0, 16'h003c, 3'b001);
    chk({15'h0, o_key_irq}, 16'h0000);
  endtask : t_key

  task automatic t_knob();
    knob(1'b0, 1'b1);
    knob(1'b1, 1'b1);
    knob(1'b1, 1'b0);
    acc(1'b0, 20'h80001, 16'h0, 16'h0003, 3'b001);
    acc(1'b0, 20'h80001, 16'h0, 16'h0000, 3'b001);
    knob(1'b1, 1'b1);
    knob(1'b0, 1'b1);
    acc(1'b0, 20'h80001, 16'h0, 16'hfffe, 3'b001);
    // Reads 18 cycles apart with the knob at rest report no movement
    repeat (2)
    begin
      repeat (16) @(negedge i_ref_clk);
      acc(1'b0, 20'h80001, 16'h0, 16'h0000, 3'b001);
    end
  endtask : t_knob

  // Mid-run reset with a request still up: lamps and grant clear, request wins at once
  task automatic t_reset();
    i_rst_b = 1'b0;
    @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0000);
    chk({8'h0, o_lamp}, 16'h0000);
    chk({13'h0, o_ram_sel, o_card_sel, o_rvalid}, 16'h0000);
    i_rst_b = 1'b1;
    @(negedge i_ref_clk);
    chk({12'h0, o_gnt}, 16'h0008);
  endtask : t_reset

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  // Ceiling is far above the hundred or so cycles the run needs
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      test_done();
    end
  end

  initial
  begin
    repeat (8) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    t_arb();
    t_banks();
    t_reset();
    t_key();
    t_knob();
    test_done();
  end
endmodule : sbapp_top_tb
